// ---- dv/asps_asserts.sv ----
`default_nettype none
// ============================================================
// Port-level checks on the sequencer
// ============================================================
module asps_asserts
   import asps_pkg::*;
#(
   parameter int WB_ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic cs_n_i,
   input wire logic dout_o,
   input wire logic dout_oe_o,
   input wire logic sample_connect_o,
   input wire logic [NUM_CHANNELS-1:0] analog_channel_sel_o,
   input wire logic [2:0] test_sel_o,
   input wire logic [RES_W-1:0] dac_code_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] cs_hi_r;
   logic [5:0] cs_hi_nxt;
   logic [13:0] sel_w;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Saturating count of select-high cycles; 40 outlasts synchroniser plus two filter steps.
   assign cs_hi_nxt = cs_n_i ? cs_hi_r + {5'h00, ~&cs_hi_r} : 6'h00;
   assign sel_w = {test_sel_o, analog_channel_sel_o};
   always_ff @(posedge clk_i) cs_hi_r <= rst_i ? 6'h00 : cs_hi_nxt;
   // ============================================================
   // Assertions
   // ============================================================
   a_oe_idle: assert property (cs_hi_r >= 6'h28 |-> !dout_oe_o)
      else $error("output driven while select high");
   a_oe_cause: assert property ($rose(dout_oe_o) |-> !cs_n_i && !$past(cs_n_i, 8))
      else $error("output enabled without settled select");
   a_sel_map: assert property (sample_connect_o == |sel_w && $onehot0(sel_w))
      else $error("input select inconsistent");
   a_dout_zero: assert property ($fell(sample_connect_o) && dout_oe_o && !cs_n_i |-> ##[0:4] !dout_o)
      else $error("serial output not low after sampling");
   a_ack_lat: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack late");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("bus ack without request");
   a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !dout_oe_o && !wb_ack_o && !sample_connect_o
      && dac_code_o == 10'h000) else $error("outputs active after reset");
endmodule
`default_nettype wire

// ---- dv/asps_host_model.sv ----
`default_nettype none
// ============================================================
// Host serial controller
// ============================================================
module asps_host_model (
   input wire logic clk_i,
   input wire logic dout_i,
   input wire logic dout_oe_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic din_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_r = 1'b0;
   wire line_w = dout_oe_i ? dout_i : ~last_r;
   // A released line shows the inverse of its last level, so stale data cannot pass.
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o = 1'b0;
   end
   always @(posedge clk_i) if (dout_oe_i) last_r <= dout_i;
   // Select change; returns once the enable follows, within a bound.
   task automatic select(input logic lvl, output logic ok);
      int n;
      n = 0;
      cs_n_o <= lvl;
      do begin
         @(posedge clk_i);
         n++;
      end while (dout_oe_i !== !lvl && n < 100);
      ok = (n < 100);
   endtask
   task automatic glitch(input int n);
      cs_n_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      cs_n_o <= 1'b1;
   endtask
   // The shift clock stands still between frames; an optional pause splits a frame.
   task automatic xfer(input logic [3:0] a, input int n, input int gap_at, input int gap, output logic [15:0] got);
      got = 16'h0000;
      for (int i = 0; i < n; i++) begin
         if (i == gap_at) repeat (gap) @(posedge clk_i);
         din_o <= (i < 4) ? a[3 - i] : ~din_o;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         got[15 - i] = line_w;
         sclk_o <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ---- dv/asps_tb.sv ----
`default_nettype none
// ============================================================
// Checker attachment
// ============================================================
bind asps_top asps_asserts #(.WB_ADR_W(WB_ADR_W)) u_asps_asserts (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cs_n_i(cs_n_i), .dout_o(dout_o),
   .dout_oe_o(dout_oe_o), .sample_connect_o(sample_connect_o), .analog_channel_sel_o(analog_channel_sel_o),
   .test_sel_o(test_sel_o), .dac_code_o(dac_code_o));
module testbench
   import asps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, conv_clk = 1'b0, comp = 1'b0, oe_q = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, cs_n, sclk, din, dout, dout_oe, sconn, ok;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
   logic [10:0] asel;
   logic [2:0] tsel;
   logic [9:0] dac, level = 10'h000, prev;
   logic [13:0] seen = 14'h0000;
   logic [15:0] got;
   int bad_count = 0, cmp_count = 0, oe_cnt = 0;
   // Conversion clock runs free on an unrelated period.
   always #4 clk_i = ~clk_i;
   always #47 conv_clk = ~conv_clk;
   // Comparator: analog level at or above the trial code keeps the bit.
   always @(posedge clk_i) comp <= (dac <= level);
   // Monitors of input selection and of output enable starts.
   always @(posedge clk_i) begin
      seen <= sconn ? {tsel, asel} : seen;
      oe_q <= dout_oe;
      if (dout_oe && !oe_q) oe_cnt <= oe_cnt + 1;
   end
   asps_top u_asps_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .conversion_clock_i(conv_clk), .comp_i(comp), .dout_o(dout),
      .dout_oe_o(dout_oe), .sample_connect_o(sconn), .analog_channel_sel_o(asel), .test_sel_o(tsel),
      .dac_code_o(dac));
   asps_host_model u_asps_host_model (.clk_i(clk_i), .dout_i(dout), .dout_oe_i(dout_oe), .cs_n_o(cs_n),
      .sclk_o(sclk), .din_o(din));
   // ============================================================
   // Shared tasks
   // ============================================================
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
      cmp_count++;
      if (a !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, a);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      chk("ack_wait", 32'h2, 32'(n));
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic sel(input logic lvl);
      u_asps_host_model.select(lvl, ok);
      chk("sel_ok", 32'h1, 32'(ok));
      chk("dout_oe", 32'(!lvl), 32'(dout_oe));
   endtask
   task automatic xf(input logic [3:0] a, input int n, input int ga, input int gp, input logic [9:0] e);
      u_asps_host_model.xfer(a, n, ga, gp, got);
      chk("dout_data", {22'h0, e}, {22'h0, got[15:6]});
      chk("dout_tail", 32'h0, {26'h0, got[5:0]});
   endtask
   // Polling the status bus, bounded, until the engine is idle again.
   task automatic wait_done;
      int n;
      n = 0;
      repeat (20) @(posedge clk_i);
      do begin
         bus(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rd[1] !== 1'b0 && n < 400);
      chk("busy", 32'h0, 32'(rd[1]));
   endtask
   function automatic logic [9:0] lv(input logic [3:0] a);
      case (a)
         TEST_HALF: lv = 10'h200;
         TEST_ZERO: lv = 10'h000;
         TEST_FULL: lv = 10'h3FF;
         default: lv = {6'h00, a} * 10'h05D + 10'h011;
      endcase
   endfunction
   // ============================================================
   // Scenarios
   // ============================================================
   task automatic t_regs;
      bus(1'b1, OFS_RESULT, 32'hFFFF);
      bus(1'b1, 8'h10, 32'hFFFF);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", 32'h1, rd);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      bus(1'b0, OFS_RESULT, 32'h0);
      chk("result", 32'h0, rd);
      bus(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test regs done");
   endtask
   task automatic t_idle;
      int c;
      c = oe_cnt;
      u_asps_host_model.xfer(4'hF, 16, 99, 0, got);
      u_asps_host_model.glitch(3);
      repeat (60) @(posedge clk_i);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl_off", 32'h0, rd);
      u_asps_host_model.glitch(60);
      bus(1'b1, OFS_CTRL, 32'h1);
      chk("oe_starts", c, oe_cnt);
      $display("test idle done");
   endtask
   task automatic t_first;
      level <= lv(TEST_FULL);
      sel(1'b0);
      u_asps_host_model.xfer(TEST_FULL, 10, 99, 0, got);
      sel(1'b1);
      wait_done;
      bus(1'b0, OFS_COUNT, 32'h0);
      chk("count", 32'h1, rd);
      prev = 10'h3FF;
      $display("test first done");
   endtask
   task automatic t_codes;
      for (int a = 0; a < 14; a++) begin
         level <= lv(4'(a));
         sel(1'b0);
         xf(4'(a), 10 + a % 7, 99, 0, prev);
         chk("in_sel", 32'h1 << a, {18'h0, seen});
         sel(1'b1);
         wait_done;
         bus(1'b0, OFS_RESULT, 32'h0);
         prev = lv(4'(a));
         chk("result", {22'h0, prev}, rd);
      end
      $display("test codes done");
   endtask
   task automatic t_abort;
      level <= 10'h155;
      sel(1'b0);
      xf(4'h1, 10, 99, 0, prev);
      sel(1'b1);
      sel(1'b0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("busy", 32'h0, 32'(rd[1]));
      bus(1'b0, OFS_RESULT, 32'h0);
      chk("result", {22'h0, prev}, rd);
      xf(4'h2, 10, 99, 0, prev);
      sel(1'b1);
      wait_done;
      prev = 10'h155;
      $display("test abort done");
   endtask
   // Select held low: short, split sixteen, long sixteen and short transfers in turn.
   task automatic t_held;
      sel(1'b0);
      level <= 10'h2C3;
      xf(4'h3, 10, 99, 0, prev);
      wait_done;
      level <= 10'h1E7;
      xf(4'h4, 16, 8, 30, 10'h2C3);
      wait_done;
      level <= 10'h0F0;
      xf(4'h5, 16, 11, 800, 10'h1E7);
      xf(4'h6, 10, 99, 0, 10'h0F0);
      sel(1'b1);
      wait_done;
      $display("test held done");
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs;
      t_idle;
      t_first;
      t_codes;
      t_abort;
      t_held;
      give_verdict;
   end
   // Watchdog sized at a few times the expected run.
   initial begin
      #400000;
      bad_count++;
      give_verdict;
   end
endmodule
`default_nettype wire

// ---- hw/asps_pkg.sv ----
`default_nettype none
package asps_pkg;
   // ============================================================
   // Result, address and transfer geometry
   // ============================================================
   localparam int RES_W = 10;
   localparam int ADDR_W = 4;
   localparam logic [4:0] XFER_SHORT = 5'd10;
   localparam logic [4:0] XFER_LONG = 5'd16;
   localparam logic [2:0] ADDR_BITS = 3'd4;
   localparam logic [4:0] SAMPLE_START = 5'd4;
   localparam logic [5:0] CONV_CYCLES = 6'd44;
   localparam logic [1:0] CS_FILTER_EDGES = 2'd2;
   localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

   // ============================================================
   // Address codes
   // ============================================================
   localparam logic [3:0] LAST_CHANNEL = 4'hA;
   localparam logic [3:0] TEST_HALF = 4'hB;
   localparam logic [3:0] TEST_ZERO = 4'hC;
   localparam logic [3:0] TEST_FULL = 4'hD;
   localparam int NUM_CHANNELS = 11;

   // ============================================================
   // Register map and reset values
   // ============================================================
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0C;
   localparam logic CTRL_EN_RST = 1'b1;

   // Serial port phases.
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_SHIFT = 2'b01,
      ST_CONV = 2'b10,
      ST_WAIT = 2'b11
   } asps_state_t;
endpackage
`default_nettype wire

// ---- hw/asps_sar.sv ----
`default_nettype none
// ============================================================
// Successive approximation engine on conversion clock steps
// ============================================================
module asps_sar
   import asps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic step_i,
   input wire logic comp_i,
   output logic busy_o,
   output logic done_o,
   output logic [RES_W-1:0] code_o,
   output logic [RES_W-1:0] result_o
);
   logic [5:0] cyc_r;
   logic [RES_W-1:0] mask_r;
   logic busy_r;
   logic done_r;
   logic [RES_W-1:0] code_r;
   logic [RES_W-1:0] result_r;

   // One trial bit is decided every fourth step; comparator high keeps it.
   wire decide = step_i & busy_r & (cyc_r[1:0] == 2'b11) & (mask_r != '0);
   wire last_step = step_i & busy_r & (cyc_r == CONV_CYCLES - 6'd1);
   wire [RES_W-1:0] code_nxt = (code_r & ~(mask_r & {RES_W{~comp_i}})) | (mask_r >> 1);

   // Abort leaves the result register alone so the older result survives.
   always_ff @(posedge clk_i) begin
      if (rst_i || abort_i) begin
         busy_r <= 1'b0;
         cyc_r <= '0;
         mask_r <= '0;
         code_r <= '0;
      end else if (start_i) begin
         busy_r <= 1'b1;
         cyc_r <= '0;
         mask_r <= SAR_FIRST_TRIAL;
         code_r <= SAR_FIRST_TRIAL;
      end else if (step_i && busy_r) begin
         cyc_r <= cyc_r + 6'd1;
         busy_r <= ~last_step;
         if (decide) begin
            code_r <= code_nxt;
            mask_r <= mask_r >> 1;
         end
      end
   end

   // The final step writes the output data register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_r <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= last_step & ~abort_i;
         if (last_step && !abort_i) begin
            result_r <= code_r;
         end
      end
   end

   assign busy_o = busy_r;
   assign done_o = done_r;
   assign code_o = code_r;
   assign result_o = result_r;
endmodule
`default_nettype wire

// ---- hw/asps_sync.sv ----
`default_nettype none
// ============================================================
// Two-stage synchroniser with edge detection
// ============================================================
module asps_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] prev_r;

   // The first stage feeds only the second; edges are taken after it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Edge pulses last one clock.
   assign q_o = sync_r;
   assign rise_o = sync_r & ~prev_r;
   assign fall_o = ~sync_r & prev_r;
endmodule
`default_nettype wire

// ---- hw/asps_top.sv ----
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module asps_top
   import asps_pkg::*;
#(
   parameter int WB_ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic din_i,
   input wire logic conversion_clock_i,
   input wire logic comp_i,
   output logic dout_o,
   output logic dout_oe_o,
   output logic sample_connect_o,
   output logic [NUM_CHANNELS-1:0] analog_channel_sel_o,
   output logic [2:0] test_sel_o,
   output logic [RES_W-1:0] dac_code_o
);
   // ============================================================
   // Pin synchronisation
   // ============================================================
   logic [4:0] pin_q;
   logic [4:0] pin_rise;
   logic [4:0] pin_fall;

   // Every pin, both foreign clocks included, is sampled by clk_i.
   // Select enters inverted so the cleared stages read as deselected and no false select follows reset.
   asps_sync #(.WIDTH(5)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({comp_i, conversion_clock_i, din_i, sclk_i, ~cs_n_i}),
      .q_o(pin_q),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   wire cs_act_s = pin_q[0];
   wire sclk_rise = pin_rise[1];
   wire sclk_fall = pin_fall[1];
   wire din_s = pin_q[2];
   wire conv_rise = pin_rise[3];
   wire conv_fall = pin_fall[3];
   wire comp_s = pin_q[4];

   // ============================================================
   // Registers and state
   // ============================================================
   logic ctrl_en_r;
   logic cs_low_r;
   logic [1:0] flt_cnt_r;
   asps_state_t st_r;
   asps_state_t st_nxt;
   logic [4:0] bit_cnt_r;
   logic [2:0] rise_cnt_r;
   logic [ADDR_W-1:0] addr_r;
   logic rise_after10_r;
   logic [RES_W-1:0] out_sr_r;
   logic dout_r;
   logic sample_r;
   logic valid_r;
   logic [15:0] conv_count_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic sar_busy;
   logic sar_done;
   logic [RES_W-1:0] sar_result;
   logic [RES_W-1:0] sar_code;

   // ============================================================
   // Select recognition filter
   // ============================================================
   // A disabled port looks like a deselected one.
   wire sel_raw = cs_act_s & ctrl_en_r;
   wire sel_diff = sel_raw != cs_low_r;
   wire flt_hit = sel_diff & conv_fall & (flt_cnt_r == CS_FILTER_EDGES - 2'd1);
   wire sel_fall = flt_hit & sel_raw;
   wire sel_rise = flt_hit & ~sel_raw;

   // Glitches shorter than two conversion clock falls never reach the port,
   // which is why the conversion clock must keep running.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_low_r <= 1'b0;
         flt_cnt_r <= '0;
      end else if (!sel_diff) begin
         flt_cnt_r <= '0;
      end else if (flt_hit) begin
         cs_low_r <= sel_raw;
         flt_cnt_r <= '0;
      end else if (conv_fall) begin
         flt_cnt_r <= flt_cnt_r + 2'd1;
      end
   end

   // ============================================================
   // Serial port sequencing
   // ============================================================
   // Shift clock events count only while selected.
   wire fall_g = sclk_fall & cs_low_r & ~sel_fall;
   wire rise_g = sclk_rise & cs_low_r & ~sel_fall;
   wire tenth_fall = fall_g & (st_r == ST_SHIFT) & (bit_cnt_r == XFER_SHORT - 5'd1);
   wire sixteenth_fall = fall_g & (st_r == ST_WAIT) & (bit_cnt_r == XFER_LONG - 5'd1);
   // A transfer is long when the host clocked during conversion and still owes falls.
   wire done_long = rise_after10_r & (bit_cnt_r != XFER_LONG);
   wire done_restart = sar_done & (st_r == ST_CONV) & cs_low_r & ~done_long;
   wire port_start = sel_fall | done_restart | sixteenth_fall;
   wire sar_start = tenth_fall;
   wire sar_abort = sel_fall & sar_busy;

   // Phase selection; a recognised select fall overrides everything.
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_OFF: begin
            st_nxt = ST_OFF;
         end
         ST_SHIFT: begin
            if (tenth_fall) begin
               st_nxt = ST_CONV;
            end else if (sel_rise) begin
               st_nxt = ST_OFF;
            end
         end
         ST_CONV: begin
            if (sar_done) begin
               if (!cs_low_r) begin
                  st_nxt = ST_OFF;
               end else if (done_long) begin
                  st_nxt = ST_WAIT;
               end else begin
                  st_nxt = ST_SHIFT;
               end
            end
         end
         ST_WAIT: begin
            if (sel_rise) begin
               st_nxt = ST_OFF;
            end else if (sixteenth_fall) begin
               st_nxt = ST_SHIFT;
            end
         end
         default: begin
            st_nxt = ST_OFF;
         end
      endcase
      if (sel_fall) begin
         st_nxt = ST_SHIFT;
      end
   end

   // Counters move only on detected edges, so any slow shift clock works.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= ST_OFF;
         bit_cnt_r <= '0;
      end else begin
         st_r <= st_nxt;
         if (port_start) begin
            bit_cnt_r <= '0;
         end else if (fall_g && st_r != ST_OFF && bit_cnt_r != XFER_LONG) begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
         end
      end
   end

   // Address capture on the first four rising edges, rest of the input ignored.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rise_cnt_r <= '0;
         addr_r <= '0;
      end else if (port_start) begin
         rise_cnt_r <= '0;
      end else if (rise_g && st_r == ST_SHIFT && rise_cnt_r != ADDR_BITS) begin
         addr_r <= {addr_r[ADDR_W-2:0], din_s};
         rise_cnt_r <= rise_cnt_r + 3'd1;
      end
   end

   // A rising edge seen during conversion marks a transfer longer than ten.
   always_ff @(posedge clk_i) begin
      if (rst_i || port_start || sar_start) begin
         rise_after10_r <= 1'b0;
      end else if (rise_g && st_r == ST_CONV) begin
         rise_after10_r <= 1'b1;
      end
   end

   // ============================================================
   // Serial output
   // ============================================================
   // The SAR result register always holds the last completed conversion, so
   // loading from it gives the previous result even after an abort.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_sr_r <= '0;
         dout_r <= 1'b0;
      end else if (port_start) begin
         out_sr_r <= sar_result;
         dout_r <= sar_result[RES_W-1];
      end else if (fall_g && st_r == ST_SHIFT) begin
         out_sr_r <= {out_sr_r[RES_W-2:0], 1'b0};
         if (bit_cnt_r == XFER_SHORT - 5'd1) begin
            dout_r <= 1'b0;
         end else begin
            dout_r <= out_sr_r[RES_W-2];
         end
      end
   end

   // The pin is driven only while the port is selected.
   assign dout_o = dout_r;
   assign dout_oe_o = cs_low_r;

   // ============================================================
   // Sampling and input selection
   // ============================================================
   wire sample_set = fall_g & (st_r == ST_SHIFT) & (bit_cnt_r == SAMPLE_START - 5'd1);

   // Sampling runs from the fourth fall until leaving the shift phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_r <= 1'b0;
      end else begin
         sample_r <= (st_nxt == ST_SHIFT) & ~port_start & (sample_r | sample_set);
      end
   end

   // Channel and test voltage selects are only live while sampling.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
         assign analog_channel_sel_o[gi] = sample_r & (addr_r == 4'(gi));
      end
   endgenerate
   assign test_sel_o[0] = sample_r & (addr_r == TEST_HALF);
   assign test_sel_o[1] = sample_r & (addr_r == TEST_ZERO);
   assign test_sel_o[2] = sample_r & (addr_r == TEST_FULL);
   assign sample_connect_o = sample_r & (addr_r <= TEST_FULL);

   // ============================================================
   // Conversion engine
   // ============================================================
   asps_sar u_sar (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(sar_start),
      .abort_i(sar_abort),
      .step_i(conv_rise),
      .comp_i(comp_s),
      .busy_o(sar_busy),
      .done_o(sar_done),
      .code_o(sar_code),
      .result_o(sar_result)
   );
   assign dac_code_o = sar_code;

   // Statistics and first-result flag.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_r <= 1'b0;
         conv_count_r <= '0;
      end else if (sar_done) begin
         valid_r <= 1'b1;
         conv_count_r <= conv_count_r + 16'h0001;
      end
   end

   // ============================================================
   // Wishbone slave
   // ============================================================
   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
   // A write lands at the edge that sees ack high, while the master still holds the request.
   wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
   wire [7:0] wb_ofs = 8'(wb_adr_i);
   wire hit_ctrl = wb_ofs == OFS_CTRL;
   wire hit_status = wb_ofs == OFS_STATUS;
   wire hit_result = wb_ofs == OFS_RESULT;
   wire hit_count = wb_ofs == OFS_COUNT;
   // Status packs select, busy, valid, phase, captured address and fall count from bit 0 up.
   wire [31:0] status_w = {15'h0, bit_cnt_r, addr_r, 2'h0, st_r, 1'b0, valid_r, sar_busy, cs_low_r};
   wire [31:0] rdata_w = hit_ctrl ? {31'h0, ctrl_en_r} :
                         hit_status ? status_w :
                         hit_result ? {22'h0, sar_result} :
                         hit_count ? {16'h0000, conv_count_r} : 32'h00000000;

   // One wait state: ack follows the request by one clock, unmapped reads give zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
         ctrl_en_r <= CTRL_EN_RST;
      end else begin
         ack_r <= wb_req;
         if (wb_req && !wb_we_i) begin
            rdata_r <= rdata_w;
         end
         if (wb_wr && hit_ctrl && wb_sel_i[0]) begin
            ctrl_en_r <= wb_dat_i[0];
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;
endmodule
`default_nettype wire
